// ### src/spr_seq.sv
// power, reset and standby sequencer driving an image sensor
//
// What this block does
// - power-down is always driven, never left floating
// - internal regulator: power-down high until 5 ms after analog supply
// - external core: power-down high until 5 ms after core supply
// - release reset only 1 ms after sensor power is stable
// - master clock runs 1 ms before any register access
// - register initialisation only 20 ms after reset released
// - serial control bus used only from the ready state; requests held steady
// - a reset pulse is applied at every power-up
// - reset pulse lasts at least 1 ms
// - serial output in use: write 11 to interface bits 4:3 first
// - internal regulator: reset low before analog supply goes off
// - internal regulator: clock stops by analog supply removal
// - external core: reset low and clock stopped before core off
// - external core: supplies rise I/O, then analog, then core
// - external core: no standby, remove all supplies when idle
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "spr_consts.svh"
module spr_seq import spr_pkg::*; #(
  parameter int unsigned MS_CYCLES = `SPR_MS_CYCLES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // supply feedback
  input wire logic io_supply_good,
  input wire logic analog_supply_good,
  input wire logic core_supply_good,
  // sensor pins and supply switches
  output spr_pins_t sensor_pins,
  // serial control bus master
  output spr_bus_req_t bus_req,
  input wire logic bus_done,
  // status
  output logic init_ok
);

  // ----------------------------------------------------------------------
  // registers of the controller
  // ----------------------------------------------------------------------
  logic [3:0] ctrl_reg;
  logic ext_reg;
  logic refused_reg;
  logic sr_pend_reg;
  spr_state_t state_reg, state_next;
  logic tick, tmr_done, tmr_start;
  logic power_on, standby_req, serial_if;
  logic refuse_now;

  assign power_on = ctrl_reg[`SPR_CTRL_POWER_ON];
  assign standby_req = ctrl_reg[`SPR_CTRL_STANDBY];
  assign serial_if = ctrl_reg[`SPR_CTRL_SERIAL_IF];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ctrl_reg <= `SPR_CTRL_RESET;
    end else if (reg_wr && hit(reg_addr, `SPR_OFS_CTRL)) begin
      ctrl_reg <= reg_wdata[3:0];
    end
  end

  // supply mode is frozen for the whole powered period
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      ext_reg <= 1'b0;
    end else if (state_reg == SPR_OFF) begin
      ext_reg <= ctrl_reg[`SPR_CTRL_EXT_CORE];
    end
  end

  // standby with external core is refused
  assign refuse_now = state_reg == SPR_READY && standby_req && ext_reg;

  // sticky flag: a new refusal wins over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      refused_reg <= 1'b0;
    end else if (refuse_now) begin
      refused_reg <= 1'b1;
    end else if (reg_wr && hit(reg_addr, `SPR_OFS_STATUS) &&
                 reg_wdata[`SPR_STAT_REFUSED]) begin
      refused_reg <= 1'b0;
    end
  end

  // reset request waits for the ready state; dropped when power goes
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sr_pend_reg <= 1'b0;
    end else if (reg_wr && hit(reg_addr, `SPR_OFS_CMD) &&
                 reg_wdata[`SPR_CMD_SW_RESET]) begin
      sr_pend_reg <= 1'b1;
    end else if (state_next == SPR_SR_CMD || state_next == SPR_PD_OFF) begin
      sr_pend_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd && hit(reg_addr, `SPR_OFS_CTRL)) begin
      reg_rdata <= {28'h000_0000, ctrl_reg};
    end else if (reg_rd && hit(reg_addr, `SPR_OFS_STATUS)) begin
      reg_rdata <= {24'h00_0000, sr_pend_reg, state_reg == SPR_STANDBY,
                    refused_reg, init_ok, state_reg};
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // millisecond timing
  // ----------------------------------------------------------------------
  function automatic logic [7:0] wait_ms(input spr_state_t s);
    case (s)
      SPR_PWR_WAIT: wait_ms = `SPR_T_SUPPLY_MS;
      SPR_PD_REL: wait_ms = `SPR_T_RST_WAIT_MS;
      SPR_RST_REL: wait_ms = `SPR_T_INIT_MS;
      SPR_SR_WAIT: wait_ms = `SPR_T_SR_SETTLE_MS;
      default: wait_ms = 8'h00;
    endcase
  endfunction

  assign tmr_start = state_next != state_reg;

  spr_tick_div #(.CYCLES(MS_CYCLES)) u_tick (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .tick(tick)
  );

  spr_ms_timer #(.W(8)) u_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .tick(tick),
    .start(tmr_start),
    .load(wait_ms(state_next)),
    .done(tmr_done)
  );

  // ----------------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SPR_OFF: begin
        if (power_on) begin
          state_next = SPR_IO_UP;
        end
      end
      SPR_IO_UP: begin
        if (!power_on) begin
          state_next = SPR_PD_OFF;
        end else if (io_supply_good) begin
          state_next = SPR_AN_UP;
        end
      end
      SPR_AN_UP: begin
        if (!power_on) begin
          state_next = SPR_PD_OFF;
        end else if (analog_supply_good) begin
          state_next = ext_reg ? SPR_CORE_UP : SPR_PWR_WAIT;
        end
      end
      SPR_CORE_UP: begin
        if (!power_on) begin
          state_next = SPR_PD_OFF;
        end else if (core_supply_good) begin
          state_next = SPR_PWR_WAIT;
        end
      end
      SPR_PWR_WAIT, SPR_PD_REL, SPR_RST_REL: begin
        if (!power_on) begin
          state_next = SPR_PD_OFF;
        end else if (tmr_done) begin
          case (state_reg)
            SPR_PWR_WAIT: state_next = SPR_PD_REL;
            SPR_PD_REL: state_next = SPR_RST_REL;
            default: state_next = SPR_READY;
          endcase
        end
      end
      SPR_READY: begin
        if (!power_on) begin
          state_next = SPR_PD_OFF;
        end else if (sr_pend_reg) begin
          state_next = SPR_SR_CMD;
        end else if (standby_req && !ext_reg) begin
          state_next = serial_if ? SPR_SB_CMD : SPR_STANDBY;
        end
      end
      SPR_SB_CMD: begin
        if (bus_done) begin
          state_next = SPR_STANDBY;
        end
      end
      SPR_STANDBY: begin
        if (!power_on) begin
          state_next = SPR_PD_OFF;
        end else if (!standby_req) begin
          state_next = SPR_READY;
        end
      end
      SPR_SR_CMD: begin
        if (bus_done) begin
          state_next = SPR_SR_WAIT;
        end
      end
      SPR_SR_WAIT: begin
        if (tmr_done) begin
          state_next = SPR_READY;
        end
      end
      SPR_PD_OFF: state_next = SPR_DN_CORE;
      SPR_DN_CORE: state_next = SPR_DN_AN;
      SPR_DN_AN: state_next = SPR_DN_IO;
      SPR_DN_IO: state_next = SPR_OFF;
      default: state_next = SPR_OFF;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state_reg <= SPR_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // pins, from flip-flops
  // ----------------------------------------------------------------------
  function automatic spr_pins_t pins_of(input spr_state_t s, input logic e);
    pins_of = '0;
    case (s)
      SPR_IO_UP: pins_of.io_supply_en = 1'b1;
      SPR_AN_UP, SPR_CORE_UP, SPR_PWR_WAIT, SPR_PD_REL, SPR_RST_REL,
      SPR_READY, SPR_SB_CMD, SPR_STANDBY, SPR_SR_CMD, SPR_SR_WAIT,
      SPR_PD_OFF, SPR_DN_CORE: begin
        pins_of.io_supply_en = 1'b1;
        pins_of.analog_supply_en = 1'b1;
      end
      SPR_DN_AN: pins_of.io_supply_en = 1'b1;
      default: pins_of = '0;
    endcase
    // core only after analog is good, dropped after clock and reset
    pins_of.core_supply_en = e && s != SPR_IO_UP && s != SPR_AN_UP &&
      pins_of.analog_supply_en && s != SPR_DN_CORE;
    // held high until the supply wait is over
    pins_of.power_down_pin = s == SPR_IO_UP || s == SPR_AN_UP ||
      s == SPR_CORE_UP || s == SPR_PWR_WAIT || s == SPR_STANDBY;
    // low through power-up wait: one pulse each power-up
    pins_of.hw_reset_low_pin = s == SPR_RST_REL || s == SPR_READY ||
      s == SPR_SB_CMD || s == SPR_STANDBY || s == SPR_SR_CMD ||
      s == SPR_SR_WAIT;
    pins_of.master_clock_en = pins_of.hw_reset_low_pin ||
      s == SPR_PD_REL;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sensor_pins <= '0;
    end else begin
      sensor_pins <= pins_of(state_next, ext_reg);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      init_ok <= 1'b0;
    end else begin
      init_ok <= state_next == SPR_READY || state_next == SPR_STANDBY;
    end
  end

  // ----------------------------------------------------------------------
  // serial control bus requests, held until done
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      bus_req <= '0;
    end else if (bus_req.valid && bus_done) begin
      bus_req <= '0;
    end else if (state_next == SPR_SB_CMD && !bus_req.valid) begin
      bus_req <= {1'b1, `SPR_SENS_IF_CTRL, `SPR_SENS_IF_SLEEP};
    end else if (state_next == SPR_SR_CMD && !bus_req.valid) begin
      bus_req <= {1'b1, `SPR_SENS_SYS_CTRL, `SPR_SENS_SYS_RESET};
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  logic [7:0] low_ms_reg;

  // ticks seen while reset pin low, saturating
  always_ff @(posedge clk_sys) begin
    if (!resetn || sensor_pins.hw_reset_low_pin) begin
      low_ms_reg <= 8'h00;
    end else if (tick && low_ms_reg != 8'hff) begin
      low_ms_reg <= low_ms_reg + 8'h01;
    end
  end

  a_pd_release_wait: assert property (@(posedge clk_sys)
    disable iff (!resetn) $fell(sensor_pins.power_down_pin) &&
    sensor_pins.master_clock_en && $past(state_reg) != SPR_STANDBY |->
    $past(state_reg) == SPR_PWR_WAIT && $past(tmr_done))
    else $error("power-down released before supply wait");
  a_rst_release_wait: assert property (@(posedge clk_sys)
    disable iff (!resetn) $rose(sensor_pins.hw_reset_low_pin) |->
    $past(tmr_done) && $past(state_reg) == SPR_PD_REL)
    else $error("reset released too early");
  a_clock_before_rst: assert property (@(posedge clk_sys)
    disable iff (!resetn) $rose(sensor_pins.hw_reset_low_pin) |->
    $past(sensor_pins.master_clock_en, 2))
    else $error("clock not running before reset release");
  a_init_after_wait: assert property (@(posedge clk_sys)
    disable iff (!resetn) $rose(init_ok) |->
    ($past(state_reg) == SPR_SB_CMD && $past(bus_done)) ||
    ($past(tmr_done) && ($past(state_reg) == SPR_RST_REL ||
    $past(state_reg) == SPR_SR_WAIT)))
    else $error("init allowed before reset wait");
  a_bus_req_hold: assert property (@(posedge clk_sys)
    disable iff (!resetn) bus_req.valid && !bus_done |=>
    bus_req.valid && $stable(bus_req.addr) && $stable(bus_req.data))
    else $error("bus request changed while pending");
  a_rst_pulse_width: assert property (@(posedge clk_sys)
    disable iff (!resetn) $rose(sensor_pins.hw_reset_low_pin) |->
    $past(low_ms_reg) > `SPR_T_RST_PULSE_MS)
    else $error("reset pulse too short");
  a_sleep_cmd_first: assert property (@(posedge clk_sys)
    disable iff (!resetn) $rose(sensor_pins.power_down_pin) &&
    state_reg == SPR_STANDBY && serial_if |->
    $past(state_reg, 2) == SPR_SB_CMD)
    else $error("standby without interface sleep write");
  a_analog_off_order: assert property (@(posedge clk_sys)
    disable iff (!resetn) $fell(sensor_pins.analog_supply_en) |->
    !sensor_pins.hw_reset_low_pin && !sensor_pins.master_clock_en &&
    $past(!sensor_pins.hw_reset_low_pin))
    else $error("analog supply removed with reset or clock active");
  a_core_off_order: assert property (@(posedge clk_sys)
    disable iff (!resetn) $fell(sensor_pins.core_supply_en) |->
    $past(!sensor_pins.hw_reset_low_pin && !sensor_pins.master_clock_en))
    else $error("core supply removed with reset or clock active");
  a_core_up_order: assert property (@(posedge clk_sys)
    disable iff (!resetn) $rose(sensor_pins.core_supply_en) |->
    sensor_pins.analog_supply_en && sensor_pins.io_supply_en)
    else $error("core supply raised out of order");
  a_no_ext_standby: assert property (@(posedge clk_sys)
    disable iff (!resetn) state_reg == SPR_STANDBY |-> !ext_reg)
    else $error("standby entered with external core supply");

  c_ready: cover property (@(posedge clk_sys) disable iff (!resetn)
    $rose(init_ok));
  c_standby: cover property (@(posedge clk_sys) disable iff (!resetn)
    state_reg == SPR_SB_CMD ##[1:20] state_reg == SPR_STANDBY);
  c_sw_reset: cover property (@(posedge clk_sys) disable iff (!resetn)
    state_reg == SPR_SR_WAIT ##1 state_reg == SPR_READY);
  c_power_off: cover property (@(posedge clk_sys) disable iff (!resetn)
    state_reg == SPR_DN_IO ##1 state_reg == SPR_OFF);

endmodule
`default_nettype wire

// ### pkg/spr_consts.svh
// constants of the sensor power, reset and standby sequencer
`ifndef SPR_CONSTS_SVH
`define SPR_CONSTS_SVH

// ----------------------------------------------------------------------
// register map of the controller
// ----------------------------------------------------------------------
`define SPR_OFS_CTRL 8'h00
`define SPR_OFS_CMD 8'h04
`define SPR_OFS_STATUS 8'h08
`define SPR_CTRL_RESET 4'h0
`define SPR_CTRL_POWER_ON 0
`define SPR_CTRL_EXT_CORE 1
`define SPR_CTRL_STANDBY 2
`define SPR_CTRL_SERIAL_IF 3
`define SPR_CMD_SW_RESET 0
`define SPR_STAT_INIT_OK 4
`define SPR_STAT_REFUSED 5
`define SPR_STAT_STANDBY 6
`define SPR_STAT_SR_PEND 7

// ----------------------------------------------------------------------
// sensor registers reached over the serial control bus
// ----------------------------------------------------------------------
`define SPR_SENS_SYS_CTRL 16'h3008
`define SPR_SENS_SYS_RESET 8'h80
`define SPR_SENS_IF_CTRL 16'h300e
`define SPR_SENS_IF_SLEEP 8'h18

// ----------------------------------------------------------------------
// timing, in milliseconds and in cycles of clk_sys
// ----------------------------------------------------------------------
`define SPR_CLK_HZ 200000000
`define SPR_MS_CYCLES (`SPR_CLK_HZ / 1000)
`define SPR_T_SUPPLY_MS 8'd5
`define SPR_T_RST_WAIT_MS 8'd1
`define SPR_T_RST_PULSE_MS 8'd1
`define SPR_T_INIT_MS 8'd20
`define SPR_T_SR_SETTLE_MS 8'd1

`endif

// ### pkg/spr_pkg.sv
// types of the sensor power, reset and standby sequencer
package spr_pkg;

  typedef enum logic [3:0] {
    SPR_OFF = 4'h0,
    SPR_IO_UP = 4'h1,
    SPR_AN_UP = 4'h3,
    SPR_CORE_UP = 4'h2,
    SPR_PWR_WAIT = 4'h6,
    SPR_PD_REL = 4'h7,
    SPR_RST_REL = 4'h5,
    SPR_READY = 4'h4,
    SPR_SB_CMD = 4'hc,
    SPR_STANDBY = 4'hd,
    SPR_SR_CMD = 4'hf,
    SPR_SR_WAIT = 4'he,
    SPR_PD_OFF = 4'ha,
    SPR_DN_CORE = 4'hb,
    SPR_DN_AN = 4'h9,
    SPR_DN_IO = 4'h8
  } spr_state_t;

  typedef struct packed {
    logic io_supply_en;
    logic analog_supply_en;
    logic core_supply_en;
    logic power_down_pin;
    logic hw_reset_low_pin;
    logic master_clock_en;
  } spr_pins_t;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } spr_bus_req_t;

endpackage

// ### src/spr_tick_div.sv
// divider giving a one-cycle pulse once per millisecond
`timescale 1ns/1ps
`default_nettype none
module spr_tick_div #(
  parameter int unsigned CYCLES = 200000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // tick out
  output logic tick
);
  localparam int W = $clog2(CYCLES);
  logic [W-1:0] cnt_reg;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_reg <= '0;
      tick <= 1'b0;
    end else if (cnt_reg == W'(CYCLES - 1)) begin
      cnt_reg <= '0;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + W'(1);
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### src/spr_ms_timer.sv
// millisecond timer: done once more than load ticks have passed
`timescale 1ns/1ps
`default_nettype none
module spr_ms_timer #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // control
  input wire logic tick,
  input wire logic start,
  input wire logic [W-1:0] load,
  // status
  output logic done
);
  logic [W:0] cnt_reg;
  logic [W-1:0] load_reg;

  // one tick more than asked: the first tick may come right after start
  assign done = cnt_reg > {1'b0, load_reg};

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      cnt_reg <= '0;
      load_reg <= '0;
    end else if (start) begin
      cnt_reg <= '0;
      load_reg <= load;
    end else if (tick && !done) begin
      cnt_reg <= cnt_reg + (W+1)'(1);
    end
  end
endmodule
`default_nettype wire

// ### verif/spr_sensor_model.sv
// behavioural image sensor: supply feedback, control bus, host timing checks
`timescale 1ns/1ps
`default_nettype none
module spr_sensor_model import spr_pkg::*; #(
  parameter int MS = 20
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // from the sequencer; slow from the testbench
  input wire spr_pins_t sensor_pins,
  input wire spr_bus_req_t bus_req,
  input wire logic slow,
  // to the sequencer
  output logic io_supply_good,
  output logic analog_supply_good,
  output logic core_supply_good,
  output logic bus_done,
  // observation
  output logic [7:0] viol_count,
  output logic [7:0] if_ctrl_reg,
  output logic [7:0] soft_reset_count
);
  spr_pins_t p;
  spr_pins_t q;
  spr_bus_req_t held;
  logic [1:0] io_d, an_d, co_d;
  logic [7:0] sys_ctrl_reg, active_cnt;
  logic busy, bad;
  int sup_cnt, pd_cnt, rl_cnt, rh_cnt, ck_cnt, wait_cnt;

  assign p = sensor_pins;
  // supplies settle two cycles after switch-on, drop at once
  assign io_supply_good = io_d[1] & p.io_supply_en;
  assign analog_supply_good = an_d[1] & p.analog_supply_en;
  assign core_supply_good = co_d[1] & p.core_supply_en;

  // ----------------------------------------------------------------------
  // host timing checks
  // ----------------------------------------------------------------------
  always_comb begin
    bad = 1'b0;
    // only the release into run counts; an abort may drop pd early
    if (q.power_down_pin && !p.power_down_pin && p.master_clock_en &&
        sup_cnt < 5 * MS) bad = 1'b1;
    if (!q.hw_reset_low_pin && p.hw_reset_low_pin &&
        (pd_cnt < MS || rl_cnt < MS)) bad = 1'b1;
    if (bus_req.valid && !busy && !bus_done &&
        (ck_cnt < MS || rh_cnt < 20 * MS)) bad = 1'b1;
    if (busy && bus_req !== held) bad = 1'b1;
    if (q.analog_supply_en && !p.analog_supply_en &&
        (p.hw_reset_low_pin || p.master_clock_en))
      bad = 1'b1;
    if (q.core_supply_en && !p.core_supply_en &&
        (p.hw_reset_low_pin || p.master_clock_en)) bad = 1'b1;
    if ((!q.analog_supply_en && p.analog_supply_en && !io_supply_good) ||
        (!q.core_supply_en && p.core_supply_en && !analog_supply_good))
      bad = 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      q <= '0;
      io_d <= '0;
      an_d <= '0;
      co_d <= '0;
      sup_cnt <= 0;
      pd_cnt <= 0;
      rl_cnt <= 0;
      rh_cnt <= 0;
      ck_cnt <= 0;
      viol_count <= '0;
    end else begin
      q <= p;
      io_d <= {io_d[0], p.io_supply_en};
      an_d <= {an_d[0], p.analog_supply_en};
      co_d <= {co_d[0], p.core_supply_en};
      sup_cnt <= (!analog_supply_good ||
                  (p.core_supply_en && !core_supply_good)) ? 0 : sup_cnt + 1;
      pd_cnt <= p.power_down_pin ? 0 : pd_cnt + 1;
      rl_cnt <= (p.hw_reset_low_pin || !analog_supply_good) ? 0 : rl_cnt + 1;
      rh_cnt <= p.hw_reset_low_pin ? rh_cnt + 1 : 0;
      ck_cnt <= p.master_clock_en ? ck_cnt + 1 : 0;
      viol_count <= viol_count + {7'h0, bad};
    end
  end

  // ----------------------------------------------------------------------
  // sensor registers and control bus slave
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      busy <= 1'b0;
      bus_done <= 1'b0;
      held <= '0;
      wait_cnt <= 0;
      sys_ctrl_reg <= '0;
      if_ctrl_reg <= '0;
      soft_reset_count <= '0;
    end else begin
      bus_done <= 1'b0;
      // bus_done gap keeps the old request from being taken twice
      if (bus_req.valid && !busy && !bus_done) begin
        busy <= 1'b1;
        held <= bus_req;
        wait_cnt <= slow ? 30 : 0;
      end else if (busy && wait_cnt != 0) begin
        wait_cnt <= wait_cnt - 1;
      end else if (busy) begin
        busy <= 1'b0;
        bus_done <= 1'b1;
        if (held.addr == 16'h3008 && held.data[7]) begin
          sys_ctrl_reg <= '0;
          if_ctrl_reg <= '0;
          soft_reset_count <= soft_reset_count + 8'h01;
        end else if (held.addr == 16'h3008) begin
          sys_ctrl_reg <= held.data;
        end else if (held.addr == 16'h300e) begin
          if_ctrl_reg <= held.data;
        end
      end
      // pin reset wins, clock or not
      if (!p.hw_reset_low_pin) begin
        sys_ctrl_reg <= '0;
        if_ctrl_reg <= '0;
      end
    end
  end

  // internal activity: pd halts and clears it, registers untouched
  always_ff @(posedge clk_sys) begin
    if (!resetn || p.power_down_pin || !p.hw_reset_low_pin) begin
      active_cnt <= '0;
    end else if (p.master_clock_en && !sys_ctrl_reg[6]) begin
      active_cnt <= active_cnt + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ### verif/spr_seq_tb.sv
// self-checking testbench of the power, reset and standby sequencer
`timescale 1ns/1ps
`default_nettype none
module spr_seq_tb import spr_pkg::*;;
  localparam int MS = 20;
  logic clk_sys, resetn, reg_wr, reg_rd, slow, bus_done, init_ok;
  logic io_g, an_g, co_g;
  logic [7:0] reg_addr, viol_count, if_ctrl_reg, soft_reset_count;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  spr_pins_t sensor_pins;
  spr_bus_req_t bus_req;
  int bad_count, tests_run, cyc, t0;
  logic [7:0] act_cnt;

  // sensor activity counter, cleared while power-down is high
  assign act_cnt = spr_sensor_model_inst.active_cnt;

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;

  spr_seq #(.MS_CYCLES(MS)) spr_seq_inst (.clk_sys(clk_sys),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .io_supply_good(io_g), .analog_supply_good(an_g),
    .core_supply_good(co_g), .sensor_pins(sensor_pins),
    .bus_req(bus_req), .bus_done(bus_done), .init_ok(init_ok));

  spr_sensor_model #(.MS(MS)) spr_sensor_model_inst (.clk_sys(clk_sys),
    .resetn(resetn), .sensor_pins(sensor_pins), .bus_req(bus_req),
    .slow(slow), .io_supply_good(io_g), .analog_supply_good(an_g),
    .core_supply_good(co_g), .bus_done(bus_done),
    .viol_count(viol_count), .if_ctrl_reg(if_ctrl_reg),
    .soft_reset_count(soft_reset_count));

  task chk(input logic [31:0] got, input logic [31:0] exp, input string s);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, s, got, exp);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  task wait_state(input logic [3:0] code, input int lim);
    int n;
    n = 0;
    rd(8'h08);
    while (rd_val[3:0] !== code && n < lim) begin
      rd(8'h08);
      n++;
    end
    chk({28'h0, rd_val[3:0]}, {28'h0, code}, "state");
  endtask

  task pins(input logic [5:0] e);
    chk({26'h0, sensor_pins}, {26'h0, e}, "pins");
  endtask

  task finish_test;
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // a full run needs about 1300 cycles
  initial begin
    #100us;
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    finish_test;
  end

  initial begin
    clk_sys = 1'b0;
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    slow = 1'b0;
    cyc = 0;
    bad_count = 0;
    tests_run = 0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    rd(8'h00);
    chk(rd_val, 32'h0, "ctrl reset");
    rd(8'h08);
    chk(rd_val, 32'h0, "status reset");
    wr(8'h0c, 32'hff);
    rd(8'h0c);
    chk(rd_val, 32'h0, "unmapped");
    pins(6'h00);
    $display("test reset done");
    // abort while waiting on supplies
    wr(8'h00, 32'h1);
    wait_state(4'h6, 50);
    pins(6'b110100);
    wr(8'h00, 32'h0);
    wait_state(4'h0, 20);
    pins(6'h00);
    $display("test abort done");
    // internal regulator power-up
    t0 = cyc;
    wr(8'h00, 32'h1);
    wait_state(4'h4, 400);
    chk({31'h0, cyc - t0 >= 26 * MS}, 32'h1, "early");
    chk({31'h0, cyc - t0 < 31 * MS}, 32'h1, "late");
    pins(6'b110011);
    chk({31'h0, init_ok}, 32'h1, "init_ok");
    $display("test power-up done");
    // hardware standby with serial output, slow bus
    slow <= 1'b1;
    wr(8'h00, 32'hd);
    wait_state(4'hd, 60);
    chk({31'h0, rd_val[6]}, 32'h1, "standby flag");
    chk({24'h0, if_ctrl_reg}, 32'h18, "if ctrl");
    pins(6'b110111);
    chk({24'h0, act_cnt}, 32'h0, "halted");
    wr(8'h00, 32'h9);
    wait_state(4'h4, 10);
    pins(6'b110011);
    chk({24'h0, if_ctrl_reg}, 32'h18, "kept");
    chk({31'h0, act_cnt != 8'h00}, 32'h1, "running");
    $display("test standby done");
    // soft reset
    slow <= 1'b0;
    wr(8'h04, 32'h1);
    rd(8'h04);
    chk(rd_val, 32'h0, "cmd read");
    repeat (4) @(posedge clk_sys);
    wait_state(4'h4, 100);
    chk({24'h0, soft_reset_count}, 32'h1, "soft reset");
    chk({24'h0, if_ctrl_reg}, 32'h0, "defaults");
    pins(6'b110011);
    // standby without serial output writes nothing
    wr(8'h00, 32'h5);
    wait_state(4'hd, 20);
    chk({24'h0, if_ctrl_reg}, 32'h0, "no write");
    wr(8'h00, 32'h1);
    wait_state(4'h4, 10);
    wr(8'h00, 32'h0);
    wait_state(4'h0, 20);
    pins(6'h00);
    $display("test soft reset done");
    // external core supply
    wr(8'h00, 32'h3);
    wait_state(4'h4, 400);
    pins(6'b111011);
    wr(8'h00, 32'h7);
    repeat (4) @(posedge clk_sys);
    rd(8'h08);
    chk({24'h0, rd_val[7:0]}, 32'h34, "refused");
    // a standing request would set the flag again, so drop it first
    wr(8'h00, 32'h3);
    wr(8'h08, 32'h20);
    rd(8'h08);
    chk({24'h0, rd_val[7:0]}, 32'h14, "cleared");
    wr(8'h00, 32'h0);
    wait_state(4'h0, 20);
    pins(6'h00);
    chk({24'h0, viol_count}, 32'h0, "timing");
    $display("test external core done");
    finish_test;
  end
endmodule
`default_nettype wire
